// *** design/adcfr_consts.vh ***
// constants for the conversion frame readout and realignment block
`ifndef ADCFR_CONSTS_VH
`define ADCFR_CONSTS_VH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define ADCFR_WORD_BITS    24
`define ADCFR_DATA_BITS    192
`define ADCFR_FRAME_BITS   216
`define ADCFR_BITCNT_W     8
`define ADCFR_BITCNT_ZERO  8'h00
`define ADCFR_BITCNT_FULL  8'hd8
`define ADCFR_ST_REALIGN   23
`define ADCFR_ST_CNT_HI    22
`define ADCFR_ST_CNT_LO    21
`define ADCFR_ST_PAD_BITS  21

// ----------------------------------------------------------------------
// result fifo
// ----------------------------------------------------------------------
`define ADCFR_FCNT_EMPTY   2'h0
`define ADCFR_FCNT_ONE     2'h1
`define ADCFR_FCNT_FULL    2'h2

// ----------------------------------------------------------------------
// conversion timing, in master clock edges
// ----------------------------------------------------------------------
`define ADCFR_PHASE_W      10
`define ADCFR_PHASE_ZERO   10'h000
`define ADCFR_PHASE_LAST   10'h3ff

// ----------------------------------------------------------------------
// result ready pulse width
// ----------------------------------------------------------------------
// 2000 ns at the 50 MHz system clock
`define ADCFR_RDY_CYC      8'h64
`define ADCFR_RDYCNT_W     8
`define ADCFR_RDYCNT_ZERO  8'h00

// ----------------------------------------------------------------------
// pin idle levels: select, sync, serial clock, master clock
// ----------------------------------------------------------------------
// synchronisers start at these so no false edge follows reset
`define ADCFR_PIN_IDLE     4'hc

`endif

// *** design/adcfr_readout.v ***
// conversion frame readout, result fifo and realignment check
`timescale 1ns/1ps
`include "adcfr_consts.vh"

// Operation
// - output floats while synchronised chip select is high
// - two-deep fifo; overflow halves ready rate
// - short frame leaves result unconsumed
// - misaligned sync pulse sets realign flag
// - sync checks alignment; conversions free-run
// - synced devices convert at same instants
module adcfr_readout
(
  input  wire                        sys_clk,
  input  wire                        rst,
  input  wire                        master_clock_input,
  input  wire                        sync_reset_n,
  input  wire                        cs_n,
  input  wire                        sclk,
  input  wire [`ADCFR_DATA_BITS-1:0] conv_data,
  output wire                        dout,
  output wire                        dout_oe,
  output reg                         result_ready_n,
  output reg                         realign_event_flag,
  output wire                        conv_strobe
);

  localparam [`ADCFR_RDYCNT_W-1:0] RDY_CYC = `ADCFR_RDY_CYC;

  wire                        mclk_s;
  wire                        sync_n_s;
  wire                        cs_n_s;
  wire                        sclk_s;
  reg                         mclk_d_r;
  reg                         sync_n_d_r;
  reg                         cs_n_d_r;
  reg                         sclk_d_r;
  wire                        mclk_rise;
  wire                        sync_fall;
  wire                        cs_fall;
  wire                        cs_rise;
  wire                        sclk_rise;
  wire                        sclk_fall;

  reg  [`ADCFR_PHASE_W-1:0]   phase_r;
  reg                         conv_tick_r;
  reg                         realign_set;

  reg  [`ADCFR_DATA_BITS-1:0] head_r;
  reg  [`ADCFR_DATA_BITS-1:0] tail_r;
  reg  [1:0]                  fcnt_r;
  reg  [`ADCFR_DATA_BITS-1:0] head_nxt;
  reg  [`ADCFR_DATA_BITS-1:0] tail_nxt;
  reg  [1:0]                  fcnt_nxt;
  reg                         rdy_fire;
  wire                        pop;

  reg  [`ADCFR_FRAME_BITS-1:0] shift_r;
  reg  [`ADCFR_BITCNT_W-1:0]  bitcnt_r;
  reg                         frame_done_r;
  reg                         dout_r;
  reg  [`ADCFR_RDYCNT_W-1:0]  rdycnt_r;
  wire [`ADCFR_WORD_BITS-1:0] status_word;

  // ----------------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------------
  adcfr_sync2
  #(
    .WIDTH (4),
    .INIT  (`ADCFR_PIN_IDLE)
  )
  u_sync
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   ({cs_n, sync_reset_n, sclk, master_clock_input}),
    .pin_sync ({cs_n_s, sync_n_s, sclk_s, mclk_s})
  );

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      mclk_d_r   <= 1'b0;
      sync_n_d_r <= 1'b1;
      cs_n_d_r   <= 1'b1;
      sclk_d_r   <= 1'b0;
    end
    else
    begin
      mclk_d_r   <= mclk_s;
      sync_n_d_r <= sync_n_s;
      cs_n_d_r   <= cs_n_s;
      sclk_d_r   <= sclk_s;
    end
  end

  assign mclk_rise = mclk_s & ~mclk_d_r;
  assign sync_fall = ~sync_n_s & sync_n_d_r;
  assign cs_fall   = ~cs_n_s & cs_n_d_r;
  assign cs_rise   = cs_n_s & ~cs_n_d_r;
  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

  // ----------------------------------------------------------------------
  // sample period timing
  // ----------------------------------------------------------------------
  // conversions run from the master clock alone; a sync edge that lands
  // on the period boundary changes nothing, any other edge realigns
  always @*
  begin
    realign_set = sync_fall & mclk_rise &
                  (phase_r != `ADCFR_PHASE_LAST);
    if (sync_fall & ~mclk_rise)
      realign_set = (phase_r != `ADCFR_PHASE_ZERO);
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      phase_r     <= `ADCFR_PHASE_ZERO;
      conv_tick_r <= 1'b0;
    end
    else
    begin
      conv_tick_r <= 1'b0;
      if (realign_set)
        phase_r <= `ADCFR_PHASE_ZERO;
      else if (mclk_rise)
      begin
        if (phase_r == `ADCFR_PHASE_LAST)
        begin
          phase_r     <= `ADCFR_PHASE_ZERO;
          conv_tick_r <= 1'b1;
        end
        else
          phase_r <= phase_r + 1'b1;
      end
    end
  end

  assign conv_strobe = conv_tick_r;

  // ----------------------------------------------------------------------
  // two-deep result fifo
  // ----------------------------------------------------------------------
  // a frame cut short never pops, so the same result is shown again
  assign pop = cs_rise & frame_done_r &
               (fcnt_r != `ADCFR_FCNT_EMPTY);

  always @*
  begin
    head_nxt = head_r;
    tail_nxt = tail_r;
    fcnt_nxt = fcnt_r;
    rdy_fire = 1'b0;
    if (pop)
    begin
      head_nxt = tail_r;
      fcnt_nxt = fcnt_r - 1'b1;
    end
    if (conv_tick_r)
    begin
      case (fcnt_nxt)
        `ADCFR_FCNT_EMPTY:
        begin
          head_nxt = conv_data;
          fcnt_nxt = `ADCFR_FCNT_ONE;
          rdy_fire = 1'b1;
        end
        `ADCFR_FCNT_ONE:
        begin
          tail_nxt = conv_data;
          fcnt_nxt = `ADCFR_FCNT_FULL;
        end
        default:
        begin
          // overflow drops both unread results: ready fires every
          // second period while nobody reads
          head_nxt = conv_data;
          fcnt_nxt = `ADCFR_FCNT_ONE;
          rdy_fire = 1'b1;
        end
      endcase
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      head_r <= {`ADCFR_DATA_BITS{1'b0}};
      tail_r <= {`ADCFR_DATA_BITS{1'b0}};
      fcnt_r <= `ADCFR_FCNT_EMPTY;
    end
    else
    begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      fcnt_r <= fcnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // result ready output
  // ----------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      result_ready_n <= 1'b1;
      rdycnt_r       <= `ADCFR_RDYCNT_ZERO;
    end
    else if (rdy_fire)
    begin
      result_ready_n <= 1'b0;
      rdycnt_r       <= RDY_CYC - 1'b1; // first low cycle counts too
    end
    else if (cs_fall | (rdycnt_r == `ADCFR_RDYCNT_ZERO))
    begin
      result_ready_n <= 1'b1;
      rdycnt_r       <= `ADCFR_RDYCNT_ZERO;
    end
    else
      rdycnt_r <= rdycnt_r - 1'b1;
  end

  // ----------------------------------------------------------------------
  // realign flag: cleared by a complete frame, a new event wins
  // ----------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
      realign_event_flag <= 1'b0;
    else if (realign_set)
      realign_event_flag <= 1'b1;
    else if (cs_rise & frame_done_r)
      realign_event_flag <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // output frame shifter
  // ----------------------------------------------------------------------
  assign status_word = {realign_event_flag, fcnt_r,
                        {`ADCFR_ST_PAD_BITS{1'b0}}};

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      shift_r      <= {`ADCFR_FRAME_BITS{1'b0}};
      bitcnt_r     <= `ADCFR_BITCNT_ZERO;
      frame_done_r <= 1'b0;
      dout_r       <= 1'b0;
    end
    else if (cs_fall)
    begin
      shift_r      <= {status_word, head_r};
      bitcnt_r     <= `ADCFR_BITCNT_ZERO;
      frame_done_r <= 1'b0;
      dout_r       <= 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        dout_r  <= shift_r[`ADCFR_FRAME_BITS-1];
        shift_r <= {shift_r[`ADCFR_FRAME_BITS-2:0], 1'b0};
      end
      // every slot, disabled channels too, must be clocked
      if (sclk_fall & ~frame_done_r)
      begin
        bitcnt_r <= bitcnt_r + 1'b1;
        if (bitcnt_r == `ADCFR_BITCNT_FULL - 1'b1)
          frame_done_r <= 1'b1;
      end
      if (cs_rise)
        frame_done_r <= 1'b0;
    end
  end

  // synchronised select gates the driver, so it lags the pin by up to
  // two clocks; the host must leave that gap between devices
  assign dout_oe = ~cs_n_s;
  assign dout    = dout_r & ~cs_n_s;

endmodule

// *** design/adcfr_sync2.v ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module adcfr_sync2
#(
  parameter          WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
  input  wire             sys_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_sync
);

  reg [WIDTH-1:0] meta_r;

  // ----------------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_r   <= INIT;
      pin_sync <= INIT;
    end
    else
    begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule

// *** verif/adcfr_host_model.sv ***
// host side model: serial controller reading conversion frames
`timescale 1ns/1ps
module adcfr_host_model
(
  input  wire miso,
  output reg  cs_n,
  output reg  sclk
);
  reg [215:0] frame;
  integer     i;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    frame = 216'h0;
  end

  // clock stands low between frames; offset keeps edges off sys_clk
  task read_frame(input integer nbits);
    begin
      #7;
      cs_n = 1'b0;
      #160;
      for (i = 0; i < nbits; i = i + 1)
      begin
        sclk = 1'b1;
        #80;
        frame = {frame[214:0], miso};
        sclk = 1'b0;
        #80;
      end
      // select is released after every frame, never tied low
      cs_n = 1'b1;
      #200;
    end
  endtask
endmodule

// *** verif/adcfr_props.sv ***
// concurrent checks on the readout block ports
`timescale 1ns/1ps
module adcfr_props
(
  input wire sys_clk,
  input wire rst,
  input wire sync_reset_n,
  input wire cs_n,
  input wire dout,
  input wire dout_oe,
  input wire result_ready_n,
  input wire realign_event_flag,
  input wire conv_strobe
);
  reg [7:0] lo_cnt_r;

  always @(posedge sys_clk)
    if (rst || result_ready_n)
      lo_cnt_r <= 8'h00;
    else
      lo_cnt_r <= lo_cnt_r + 8'h01;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_float_desel: assert property (cs_n[*4] |-> !dout_oe)
    else $error("data driver on while deselected");
  chk_dout_idle: assert property (!dout_oe |-> !dout)
    else $error("data line not idle while released");
  chk_oe_on: assert property ($fell(cs_n) ##1 !cs_n[*3] |-> dout_oe)
    else $error("driver not on after select");
  chk_strobe_gap: assert property (conv_strobe |=> !conv_strobe[*8])
    else $error("conversion strobe too close");
  chk_rdy_cause: assert property ($fell(result_ready_n)
                                  |-> $past(conv_strobe))
    else $error("ready fell without conversion");
  chk_rdy_width: assert property (!result_ready_n |-> lo_cnt_r < 8'h64)
    else $error("ready held low too long");
  chk_flag_cause: assert property ($rose(realign_event_flag)
                                   |-> !$past(sync_reset_n, 3))
    else $error("realign flag set without sync");
  chk_flag_hold: assert property ($fell(realign_event_flag)
                                  |-> cs_n && $past(cs_n, 2))
    else $error("realign flag cleared mid frame");

  cover property ($fell(result_ready_n));
  cover property ($rose(realign_event_flag));
  cover property ($fell(cs_n) ##1 !cs_n[*3]);
endmodule

bind adcfr_readout adcfr_props adcfr_props_i
(
  .sys_clk            (sys_clk),
  .rst                (rst),
  .sync_reset_n       (sync_reset_n),
  .cs_n               (cs_n),
  .dout               (dout),
  .dout_oe            (dout_oe),
  .result_ready_n     (result_ready_n),
  .realign_event_flag (realign_event_flag),
  .conv_strobe        (conv_strobe)
);

// *** verif/adcfr_readout_tb_top.sv ***
// self-checking bench for the frame readout block
`timescale 1ns/1ps
module adcfr_readout_tb_top;
  reg          sys_clk;
  reg          rst;
  reg          mclk;
  reg          sync_n;
  reg  [23:0]  seq;
  reg  [191:0] conv_data;
  reg  [191:0] last_val  = 192'h0;
  reg          rdy_q     = 1'b1;
  integer      err_count = 0;
  integer      n_tests   = 0;
  integer      cyc       = 0;
  integer      falls     = 0;
  integer      strobes   = 0;
  integer      s0;
  integer      f0;
  wire         cs_n;
  wire         sclk;
  wire         dout;
  wire         dout_oe;
  wire         rdy_n;
  wire         flag;
  wire         strobe;
  // released line reads back inverted, never a stale bit
  wire         miso  = dout_oe ? dout : ~dout;
  wire [215:0] frame = adcfr_host_model_i.frame;

  adcfr_readout adcfr_readout_i
  (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .master_clock_input (mclk),
    .sync_reset_n       (sync_n),
    .cs_n               (cs_n),
    .sclk               (sclk),
    .conv_data          (conv_data),
    .dout               (dout),
    .dout_oe            (dout_oe),
    .result_ready_n     (rdy_n),
    .realign_event_flag (flag),
    .conv_strobe        (strobe)
  );

  adcfr_host_model adcfr_host_model_i
  (
    .miso (miso),
    .cs_n (cs_n),
    .sclk (sclk)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    mclk <= cyc[1];
    rdy_q <= rdy_n;
    if (rdy_q && !rdy_n)
      falls <= falls + 1;
    if (rst)
    begin
      seq       <= 24'h000001;
      conv_data <= {8{24'h000001}};
    end
    else if (strobe)
    begin
      last_val <= conv_data;
      strobes <= strobes + 1;
      seq <= seq + 24'h000001;
      conv_data <= {8{seq + 24'h000001}};
    end
    if (cyc == 80000)
    begin
      err_count = err_count + 1;
      summarize;
    end
  end

  task check(input [63:0] nm, input [191:0] exp, input [191:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask

  task wait_rdy;
    integer k;
    begin
      for (k = 0; k < 9000 && rdy_n !== 1'b0; k = k + 1)
        @(posedge sys_clk);
    end
  endtask

  task wait_strb(input integer n);
    integer k;
    begin
      for (k = 0; k < 20000 && strobes < n; k = k + 1)
        @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
    end
  endtask

  task pulse_sync;
    begin
      @(posedge sys_clk);
      sync_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      sync_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
  endtask

  task t_first;
    begin
      check("oe_idle", 192'h0, dout_oe);
      wait_rdy;
      adcfr_host_model_i.read_frame(216);
      check("data", last_val, frame[191:0]);
      check("count", 192'h1, frame[214:213]);
    end
  endtask

  task t_short;
    begin
      wait_rdy;
      adcfr_host_model_i.read_frame(100);
      adcfr_host_model_i.read_frame(216);
      check("repeat", last_val, frame[191:0]);
    end
  endtask

  task t_overflow;
    begin
      f0 = falls;
      wait_strb(strobes + 4);
      check("halfrate", 192'h2, falls - f0);
      adcfr_host_model_i.read_frame(216);
      check("full", 192'h2, frame[214:213]);
      adcfr_host_model_i.read_frame(216);
      check("newest", last_val, frame[191:0]);
    end
  endtask

  task t_resync;
    begin
      pulse_sync;
      check("flag_set", 192'h1, flag);
      adcfr_host_model_i.read_frame(216);
      check("st_flag", 192'h1, frame[215]);
      check("flag_clr", 192'h0, flag);
      s0 = strobes;
      pulse_sync;
      check("flag_re", 192'h1, flag);
      check("nostart", s0, strobes);
      wait_strb(s0 + 1);
      check("freerun", s0 + 1, strobes);
    end
  endtask

  task summarize;
    begin
      if (err_count == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  initial
  begin
    rst    <= 1'b1;
    sync_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_first;
    t_short;
    t_overflow;
    t_resync;
    summarize;
  end
endmodule
